// [verilog/umsbg_defs.svh]
// Register offsets, field positions, reset values and timing constants.
`ifndef UMSBG_DEFS_SVH
`define UMSBG_DEFS_SVH

// ****************************************************************
// Register offsets on the 3-bit register port
// ****************************************************************
`define UMSBG_OFS_DIV_LOW      3'h0
`define UMSBG_OFS_DIV_HIGH     3'h1
`define UMSBG_OFS_STATUS       3'h6
`define UMSBG_OFS_SCRATCH      3'h7

// ****************************************************************
// Status register fields and reset values
// ****************************************************************
`define UMSBG_FLAG_CTS         0
`define UMSBG_FLAG_DSR         1
`define UMSBG_FLAG_RING        2
`define UMSBG_FLAG_DCD         3
`define UMSBG_LINE_CTS         0
`define UMSBG_LINE_DSR         1
`define UMSBG_LINE_RING        2
`define UMSBG_LINE_DCD         3
`define UMSBG_RST_FLAGS        4'h0
`define UMSBG_RST_PINS_N       4'hf
`define UMSBG_RST_LINES        4'h0
`define UMSBG_RST_SCRATCH      8'h00
`define UMSBG_RST_DIVISOR      16'h0000
`define UMSBG_RD_NONE          8'h00

// ****************************************************************
// Divisor decoding
// ****************************************************************
`define UMSBG_DIV_ZERO         16'h0000
`define UMSBG_DIV_ONE          16'h0001
`define UMSBG_DIV_TWO          16'h0002
`define UMSBG_DIV_ZERO_EFF     16'h0003
`define UMSBG_DIV_HS_X2        16'h8002
`define UMSBG_DIV_HS_X4        16'h8001
`define UMSBG_WAVE_LOW_TICKS   16'h0002

// ****************************************************************
// Clock rates in Hz and the phase step for each reference clock
// ****************************************************************
`define UMSBG_CLK_HZ           64'd100000000
`define UMSBG_REF_STD_HZ       64'd1846200
`define UMSBG_REF_X2_HZ        64'd3686400
`define UMSBG_REF_X4_HZ        64'd7372800
`define UMSBG_PHASE_ONE        64'h0000000100000000
`define UMSBG_NCO_STEP(f) (((f) * 64'd2 * `UMSBG_PHASE_ONE) / `UMSBG_CLK_HZ)
`define UMSBG_ACC_RST          32'h00000000

`endif

// [verilog/umsbg_pkg.sv]
// Types shared by the modem status and baud generator block.
`default_nettype none
package umsbg_pkg;

	// Modem lines in status bit order: carrier, ring, set ready, cts.
	typedef struct packed {
		logic carrier;
		logic ring;
		logic setReady;
		logic clearToSend;
	} umsbg_modem_type;

	// Modem control bits from the control register of the port.
	typedef struct packed {
		logic loopback;
		logic userOutputTwo;
		logic userOutputOne;
		logic requestToSend;
		logic terminalReady;
	} umsbg_ctrl_type;

	// Reference clock that feeds the baud divider.
	typedef enum logic [2:0] {
		UMSBG_REF_STD = 3'b001,
		UMSBG_REF_X2  = 3'b010,
		UMSBG_REF_X4  = 3'b100
	} umsbg_ref_type;

	// Decoded divisor: reference choice and effective count.
	typedef struct packed {
		umsbg_ref_type refSel;
		logic [15:0]   count;
	} umsbg_div_type;

endpackage
`default_nettype wire

// [verilog/umsbg_core.sv]
// Modem status register, scratch register and baud rate generator.
`include "umsbg_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module umsbg_core (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic [2:0]               regAddr,
	input  wire logic [7:0]               regWrData,
	input  wire logic                     regWrite,
	input  wire logic                     regRead,
	output logic      [7:0]               regRdData_r,
	input  wire umsbg_pkg::umsbg_modem_type modemPins_n,
	input  wire umsbg_pkg::umsbg_ctrl_type  modemCtrl,
	input  wire logic                     divisorAccessSelect,
	input  wire logic                     highSpeedSel,
	output logic                          modemStatusIrq_r,
	output logic                          baud16En_r,
	output logic                          baudWave_r
);

	// ****************************************************************
	// Constants and helpers
	// ****************************************************************

	// Phase steps: two overflows per reference clock period.
	localparam logic [63:0] STEP_STD_W = `UMSBG_NCO_STEP(`UMSBG_REF_STD_HZ);
	localparam logic [63:0] STEP_X2_W  = `UMSBG_NCO_STEP(`UMSBG_REF_X2_HZ);
	localparam logic [63:0] STEP_X4_W  = `UMSBG_NCO_STEP(`UMSBG_REF_X4_HZ);
	localparam logic [31:0] STEP_STD   = STEP_STD_W[31:0];
	localparam logic [31:0] STEP_X2    = STEP_X2_W[31:0];
	localparam logic [31:0] STEP_X4    = STEP_X4_W[31:0];

	// Turns the latched divisor and speed bit into reference and count.
	function automatic umsbg_pkg::umsbg_div_type decodeDivisor(
		input logic [15:0] divisor,
		input logic        highSpeed
	);
		umsbg_pkg::umsbg_div_type res;
		res.refSel = umsbg_pkg::UMSBG_REF_STD;
		res.count  = divisor;
		if (highSpeed && divisor == `UMSBG_DIV_HS_X2) begin
			res.refSel = umsbg_pkg::UMSBG_REF_X2;
			res.count  = `UMSBG_DIV_ONE;
		end else if (highSpeed && divisor == `UMSBG_DIV_HS_X4) begin
			res.refSel = umsbg_pkg::UMSBG_REF_X4;
			res.count  = `UMSBG_DIV_ONE;
		end else if (divisor == `UMSBG_DIV_ZERO) begin
			res.count = `UMSBG_DIV_ZERO_EFF;
		end
		return res;
	endfunction

	// True when the register port addresses the given offset.
	function automatic logic hits(
		input logic [2:0] addr,
		input logic [2:0] ofs
	);
		return addr == ofs;
	endfunction

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [3:0]               pinsMeta_r;
	logic [3:0]               pinsSync_r;
	logic [3:0]               lineNow;
	logic [3:0]               linePrev_r;
	logic [3:0]               flagSet;
	logic [3:0]               flags_r;
	logic [3:0]               flags_nxt;
	logic                     statusRead;
	logic [7:0]               scratch_r;
	logic [7:0]               divLow_r;
	logic [7:0]               divHigh_r;
	logic                     divWrite;
	logic                     reload_r;
	umsbg_pkg::umsbg_div_type divDec;
	logic [31:0]              phaseStep;
	logic [31:0]              phaseAcc_r;
	logic [32:0]              phaseSum;
	logic                     halfTick_r;
	logic                     refPhase_r;
	logic                     refPhase_nxt;
	logic                     refRise;
	logic [15:0]              baudCnt_r;
	logic [15:0]              baudCnt_nxt;
	logic                     terminal;
	logic                     wave_nxt;
	logic [7:0]               rdData_nxt;

	// ****************************************************************
	// Modem input synchronisers
	// ****************************************************************

	// two-stage pin sync
	// Each pin passes two flops; only the second stage is read.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pinsMeta_r[gi] <= 1'b1;
					pinsSync_r[gi] <= 1'b1;
				end else begin
					pinsMeta_r[gi] <= modemPins_n[gi];
					pinsSync_r[gi] <= pinsMeta_r[gi];
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Line state and loopback substitution
	// ****************************************************************

	// loopback line source
	// In loopback the pins are ignored and the control bits stand in.
	always_comb begin
		if (modemCtrl.loopback) begin
			lineNow[`UMSBG_LINE_CTS]  = modemCtrl.requestToSend;
			lineNow[`UMSBG_LINE_DSR]  = modemCtrl.terminalReady;
			lineNow[`UMSBG_LINE_RING] = modemCtrl.userOutputOne;
			lineNow[`UMSBG_LINE_DCD]  = modemCtrl.userOutputTwo;
		end else begin
			lineNow = ~pinsSync_r;
		end
	end

	// Previous sample of the effective lines, compared every cycle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			linePrev_r <= `UMSBG_RST_LINES;
		end else begin
			linePrev_r <= lineNow;
		end
	end

	// ****************************************************************
	// Change flags and modem status interrupt
	// ****************************************************************

	// compare consecutive samples
	// Each transition (for ring only a fall) shows for exactly one cycle as a set request.
	always_comb begin
		flagSet[`UMSBG_FLAG_CTS] = lineNow[`UMSBG_LINE_CTS] ^
			linePrev_r[`UMSBG_LINE_CTS];
		flagSet[`UMSBG_FLAG_DSR] = lineNow[`UMSBG_LINE_DSR] ^
			linePrev_r[`UMSBG_LINE_DSR];
		flagSet[`UMSBG_FLAG_RING] = linePrev_r[`UMSBG_LINE_RING] &
			~lineNow[`UMSBG_LINE_RING];
		flagSet[`UMSBG_FLAG_DCD] = lineNow[`UMSBG_LINE_DCD] ^
			linePrev_r[`UMSBG_LINE_DCD];
	end

	assign statusRead = regRead && hits(regAddr, `UMSBG_OFS_STATUS);

	// clear on status read
	// A change in the read cycle survives, since set beats clear.
	assign flags_nxt = (flags_r & {4{~statusRead}}) | flagSet;

	// Sticky change flags.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= `UMSBG_RST_FLAGS;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// interrupt from any flag
	// Registered so that it rises together with the flag.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modemStatusIrq_r <= 1'b0;
		end else begin
			modemStatusIrq_r <= |flags_nxt;
		end
	end

	// ****************************************************************
	// Scratch and divisor latches
	// ****************************************************************

	// scratch byte store
	// Kept purely for software; nothing else reads it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scratch_r <= `UMSBG_RST_SCRATCH;
		end else if (regWrite && hits(regAddr, `UMSBG_OFS_SCRATCH)) begin
			scratch_r <= regWrData;
		end
	end

	// two byte latches
	// Both latches are only reachable with the access select bit set.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			divLow_r  <= 8'(`UMSBG_RST_DIVISOR);
			divHigh_r <= 8'(`UMSBG_RST_DIVISOR >> 8);
		end else if (regWrite && divisorAccessSelect) begin
			if (hits(regAddr, `UMSBG_OFS_DIV_LOW)) begin
				divLow_r <= regWrData;
			end
			if (hits(regAddr, `UMSBG_OFS_DIV_HIGH)) begin
				divHigh_r <= regWrData;
			end
		end
	end

	assign divWrite = regWrite && divisorAccessSelect &&
		(hits(regAddr, `UMSBG_OFS_DIV_LOW) ||
		hits(regAddr, `UMSBG_OFS_DIV_HIGH));

	// reload after latch write
	// Delayed one cycle so the counter loads the new latch value.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reload_r <= 1'b1;
		end else begin
			reload_r <= divWrite;
		end
	end

	// ****************************************************************
	// Reference clock synthesis
	// ****************************************************************

	assign divDec = decodeDivisor({divHigh_r, divLow_r}, highSpeedSel);

	// reference rate select
	// Picks the phase step of the chosen reference clock.
	always_comb begin
		case (divDec.refSel)
			umsbg_pkg::UMSBG_REF_STD: begin
				phaseStep = STEP_STD;
			end
			umsbg_pkg::UMSBG_REF_X2: begin
				phaseStep = STEP_X2;
			end
			umsbg_pkg::UMSBG_REF_X4: begin
				phaseStep = STEP_X4;
			end
			default: begin
				phaseStep = STEP_STD;
			end
		endcase
	end

	assign phaseSum = {1'b0, phaseAcc_r} + {1'b0, phaseStep};

	// Phase accumulator; each overflow marks a reference half period.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phaseAcc_r <= `UMSBG_ACC_RST;
			halfTick_r <= 1'b0;
		end else if (reload_r) begin
			phaseAcc_r <= `UMSBG_ACC_RST;
			halfTick_r <= 1'b0;
		end else begin
			phaseAcc_r <= phaseSum[31:0];
			halfTick_r <= phaseSum[32];
		end
	end

	assign refPhase_nxt = reload_r ? 1'b0 : (refPhase_r ^ halfTick_r);
	assign refRise      = halfTick_r && !refPhase_r && !reload_r;

	// Level of the synthesised reference clock.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			refPhase_r <= 1'b0;
		end else begin
			refPhase_r <= refPhase_nxt;
		end
	end

	// ****************************************************************
	// Baud divider
	// ****************************************************************

	// programmable down counter
	// Counts reference rising edges from the effective count down to one.
	always_comb begin
		terminal    = 1'b0;
		baudCnt_nxt = baudCnt_r;
		if (reload_r) begin
			baudCnt_nxt = divDec.count;
		end else if (refRise) begin
			if (baudCnt_r <= `UMSBG_DIV_ONE) begin
				terminal    = 1'b1;
				baudCnt_nxt = divDec.count;
			end else begin
				baudCnt_nxt = baudCnt_r - `UMSBG_DIV_ONE;
			end
		end
	end

	// Divider state.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baudCnt_r <= `UMSBG_DIV_ZERO_EFF;
		end else begin
			baudCnt_r <= baudCnt_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baud16En_r <= 1'b0;
		end else begin
			baud16En_r <= terminal;
		end
	end

	// Shape of the divider output as a level, for observation.
	always_comb begin
		if (divDec.count == `UMSBG_DIV_ONE) begin
			wave_nxt = ~refPhase_nxt;
		end else if (divDec.count == `UMSBG_DIV_TWO) begin
			wave_nxt = baudCnt_nxt != `UMSBG_DIV_TWO;
		end else begin
			wave_nxt = baudCnt_nxt <= divDec.count -
				`UMSBG_WAVE_LOW_TICKS;
		end
	end

	// Registered waveform.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			baudWave_r <= 1'b0;
		end else begin
			baudWave_r <= wave_nxt;
		end
	end

	// ****************************************************************
	// Register read port
	// ****************************************************************

	// Read multiplexer; offsets owned elsewhere read as zero.
	always_comb begin
		rdData_nxt = `UMSBG_RD_NONE;
		case (regAddr)
			`UMSBG_OFS_DIV_LOW: begin
				if (divisorAccessSelect) begin
					rdData_nxt = divLow_r;
				end
			end
			`UMSBG_OFS_DIV_HIGH: begin
				if (divisorAccessSelect) begin
					rdData_nxt = divHigh_r;
				end
			end
			`UMSBG_OFS_STATUS: begin
				rdData_nxt = {lineNow, flags_r};
			end
			`UMSBG_OFS_SCRATCH: begin
				rdData_nxt = scratch_r;
			end
			default: begin
				rdData_nxt = `UMSBG_RD_NONE;
			end
		endcase
	end

	// Read data stands for the one cycle after the read strobe.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData_r <= `UMSBG_RD_NONE;
		end else if (regRead) begin
			regRdData_r <= rdData_nxt;
		end else begin
			regRdData_r <= `UMSBG_RD_NONE;
		end
	end

endmodule
`default_nettype wire

// [verif/umsbg_monitor.sv]
// Concurrent checks on the ports of the modem status and baud block.
`timescale 1ns/10ps
`default_nettype none

module umsbg_monitor (
	input wire logic                       clk,
	input wire logic                       rst_n,
	input wire logic [2:0]                 regAddr,
	input wire logic [7:0]                 regWrData,
	input wire logic                       regWrite,
	input wire logic                       regRead,
	input wire logic [7:0]                 regRdData_r,
	input wire umsbg_pkg::umsbg_modem_type modemPins_n,
	input wire umsbg_pkg::umsbg_ctrl_type  modemCtrl,
	input wire logic                       divisorAccessSelect,
	input wire logic                       highSpeedSel,
	input wire logic                       modemStatusIrq_r,
	input wire logic                       baud16En_r,
	input wire logic                       baudWave_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [7:0] scratchShadow_r;

	// Keeps the last byte written to the scratch offset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scratchShadow_r <= 8'h00;
		end else if (regWrite && regAddr == 3'h7) begin
			scratchShadow_r <= regWrData;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// idle read data.
	a_read_idle_zero: assert property (!$past(regRead) |-> regRdData_r == 8'h00)
		else $error("read data not zero outside the answer cycle");
	a_scratch_back: assert property (regRead && regAddr == 3'h7 |=> regRdData_r == $past(scratchShadow_r))
		else $error("scratch byte read back wrong");
	a_divisor_hidden: assert property (regRead && regAddr[2:1] == 2'b00 && !divisorAccessSelect |=> regRdData_r == 8'h00)
		else $error("divisor latch visible without access select");
	a_irq_flags: assert property (regRead && regAddr == 3'h6 |=> (regRdData_r[3:0] != 4'h0) == $past(modemStatusIrq_r))
		else $error("interrupt request disagrees with change flags");
	a_irq_fall_read: assert property ($fell(modemStatusIrq_r) |-> $past(regRead && regAddr == 3'h6))
		else $error("interrupt request fell without a status read");
	a_irq_cause: assert property ($rose(modemStatusIrq_r) |-> $past(modemPins_n, 1) != $past(modemPins_n, 6) || $past(modemCtrl, 1) != $past(modemCtrl, 5))
		else $error("interrupt request rose without a line change");
	a_loop_mirror: assert property (regRead && regAddr == 3'h6 && modemCtrl.loopback && $past(modemCtrl) == modemCtrl && $past(modemCtrl, 2) == modemCtrl
		|=> regRdData_r[7:4] == {$past(modemCtrl.userOutputTwo), $past(modemCtrl.userOutputOne), $past(modemCtrl.terminalReady), $past(modemCtrl.requestToSend)})
		else $error("loopback status lines wrong");
	a_pins_mirror: assert property (regRead && regAddr == 3'h6 && !modemCtrl.loopback && !$past(modemCtrl.loopback) && !$past(modemCtrl.loopback, 2) && $past(modemPins_n, 4) == modemPins_n
		|=> regRdData_r[7:4] == ~$past(modemPins_n))
		else $error("status lines are not the inverted pins");
	a_baud_one_cycle: assert property (baud16En_r |=> !baud16En_r)
		else $error("baud enable longer than one cycle");
	a_reload_quiet: assert property (regWrite && divisorAccessSelect && regAddr[2:1] == 2'b00 |-> ##2 !baud16En_r [*8])
		else $error("baud enable too soon after divisor reload");
endmodule

bind umsbg_core umsbg_monitor mon_u (
	.clk(clk),
	.rst_n(rst_n),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWrite(regWrite),
	.regRead(regRead),
	.regRdData_r(regRdData_r),
	.modemPins_n(modemPins_n),
	.modemCtrl(modemCtrl),
	.divisorAccessSelect(divisorAccessSelect),
	.highSpeedSel(highSpeedSel),
	.modemStatusIrq_r(modemStatusIrq_r),
	.baud16En_r(baud16En_r),
	.baudWave_r(baudWave_r)
);
`default_nettype wire

// [verif/umsbg_modem_model.sv]
// Modem model that drives the active-low modem status pins.
`timescale 1ns/10ps
`default_nettype none

module umsbg_modem_model (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire umsbg_pkg::umsbg_modem_type lineReq,
	input  wire logic                       slow,
	output var  umsbg_pkg::umsbg_modem_type modemPins_n
);
	logic [3:0] stage_r [3];

	// Asserted lines pass a delay line; a slow modem answers late.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_r <= '{4'h0, 4'h0, 4'h0};
			modemPins_n <= 4'hf;
		end else begin
			stage_r <= '{lineReq, stage_r[0], stage_r[1]};
			modemPins_n <= ~(slow ? stage_r[2] : stage_r[0]);
		end
	end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the modem status and baud generator block.
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic                       clk;
	logic                       rst_n;
	logic [2:0]                 regAddr;
	logic [7:0]                 regWrData;
	logic                       regWrite;
	logic                       regRead;
	logic [7:0]                 regRdData_r;
	umsbg_pkg::umsbg_modem_type modemPins_n;
	umsbg_pkg::umsbg_modem_type lineReq;
	umsbg_pkg::umsbg_ctrl_type  modemCtrl;
	logic                       divisorAccessSelect;
	logic                       highSpeedSel;
	logic                       modemStatusIrq_r;
	logic                       baud16En_r;
	logic                       baudWave_r;
	logic                       slow;
	logic                       rdPend;
	logic [3:0]                 eff;
	logic [7:0]                 lfsrState;
	logic [7:0]                 expQ [$];
	int                         failures;
	int                         compares;

	umsbg_core dut_u (
		.clk(clk),
		.rst_n(rst_n),
		.regAddr(regAddr),
		.regWrData(regWrData),
		.regWrite(regWrite),
		.regRead(regRead),
		.regRdData_r(regRdData_r),
		.modemPins_n(modemPins_n),
		.modemCtrl(modemCtrl),
		.divisorAccessSelect(divisorAccessSelect),
		.highSpeedSel(highSpeedSel),
		.modemStatusIrq_r(modemStatusIrq_r),
		.baud16En_r(baud16En_r),
		.baudWave_r(baudWave_r)
	);

	umsbg_modem_model modem_u (
		.clk(clk),
		.rst_n(rst_n),
		.lineReq(lineReq),
		.slow(slow),
		.modemPins_n(modemPins_n)
	);

	// Free-running 100 MHz clock.
	always #5 clk = ~clk;

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	// Compares one value and counts the result.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic test_done();
		$display("Counts: compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Steps the pseudo-random byte generator.
	function automatic logic [7:0] lfsr();
		lfsrState = {lfsrState[6:0],
			lfsrState[7] ^ lfsrState[5] ^ lfsrState[4] ^ lfsrState[3]};
		return lfsrState;
	endfunction

	// Flags due when the lines move from o to n (ring on release only).
	function automatic logic [3:0] flagsOf(input logic [3:0] o,
		input logic [3:0] n);
		return {o[3] ^ n[3], o[2] & ~n[2], o[1] ^ n[1], o[0] ^ n[0]};
	endfunction

	// One register write cycle.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	// One register read cycle; the expected byte goes on the queue.
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		expQ.push_back(e);
		@(posedge clk);
		regRead <= 1'b0;
	endtask

	// Read data stand in the cycle after the strobe; compare them there.
	always @(posedge clk) rdPend <= regRead;
	always @(negedge clk) begin
		if (rdPend) begin
			chk(regRdData_r, (expQ.size() > 0) ? expQ.pop_front() : 8'hxx);
		end
	end

	// Applies control bits and modem lines, then reads status twice.
	task automatic step(input umsbg_pkg::umsbg_ctrl_type c,
		input logic [3:0] l);
		logic [3:0] n;
		n = c.loopback ? {c.userOutputTwo, c.userOutputOne,
			c.terminalReady, c.requestToSend} : l;
		@(posedge clk);
		modemCtrl <= c;
		lineReq <= l;
		repeat (12) @(posedge clk);
		@(negedge clk);
		chk({7'h00, modemStatusIrq_r}, {7'h00, |flagsOf(eff, n)});
		rd(3'h6, {n, flagsOf(eff, n)});
		rd(3'h6, {n, 4'h0});
		eff = n;
	endtask

	// Loads a divisor and measures first pulse, period and low time.
	task automatic baud(input logic [15:0] dv, input logic hs);
		real rf;
		real cnt;
		real per;
		real low;
		int  t;
		rf = !hs ? 1846200.0 : (dv[0] ? 7372800.0 : 3686400.0);
		cnt = hs ? 1.0 : (dv == 16'h0000 ? 3.0 : real'(dv));
		per = cnt * 1.0e8 / rf;
		low = (cnt > 2.0 ? 4.0 : cnt) * 0.5e8 / rf;
		@(posedge clk);
		highSpeedSel <= hs;
		wr(3'h1, dv[15:8]);
		wr(3'h0, dv[7:0]);
		t = 0;
		while (baud16En_r !== 1'b1 && t < 5000) begin
			@(negedge clk);
			t++;
		end
		chk({7'h00, real'(t) <= per + 4.0}, 8'h01);
		t = 1;
		@(negedge clk);
		while (baud16En_r !== 1'b1 && t < 5000) begin
			@(negedge clk);
			t++;
		end
		chk({7'h00, real'(t) >= per - 1.5 && real'(t) <= per + 1.5}, 8'h01);
		while (baudWave_r !== 1'b0 && t < 10000) begin
			@(negedge clk);
			t++;
		end
		t = 0;
		while (baudWave_r === 1'b0 && t < 5000) begin
			@(negedge clk);
			t++;
		end
		chk({7'h00, real'(t) >= low - 2.0 && real'(t) <= low + 2.0}, 8'h01);
		$display("Test divisor %h done", dv);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		logic [7:0]  d;
		static logic [3:0]  seqT [6] = '{4'h1, 4'h3, 4'h4, 4'h0, 4'h8, 4'h0};
		static logic [15:0] divT [7] = '{16'h000c, 16'h0001, 16'h0002,
			16'h0000,
			16'h0003, 16'h8002, 16'h8001};
		clk = 1'b0;
		rst_n = 1'b0;
		regAddr = 3'h0;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		lineReq = 4'h0;
		modemCtrl = 5'h00;
		divisorAccessSelect = 1'b1;
		highSpeedSel = 1'b0;
		slow = 1'b0;
		eff = 4'h0;
		lfsrState = 8'h3d;
		failures = 0;
		compares = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(3'h7, 8'h00);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h00);
		rd(3'h6, 8'h00);
		$display("Test reset values done");
		for (int i = 0; i < 6; i++) begin
			d = lfsr();
			wr(3'h7, d);
			wr(3'h6, ~d);
			wr(3'h1, d ^ 8'h5a);
			rd(3'h7, d);
			rd(3'h1, d ^ 8'h5a);
			rd(3'(i % 4 + 2), 8'h00);
			rd(3'h6, 8'h00);
		end
		divisorAccessSelect <= 1'b0;
		wr(3'h0, 8'h77);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'h00);
		divisorAccessSelect <= 1'b1;
		rd(3'h0, 8'h00);
		$display("Test registers done");
		foreach (seqT[i]) step(5'h00, seqT[i]);
		for (int i = 0; i < 8; i++) begin
			d = lfsr();
			slow <= d[7];
			step(5'h00, d[3:0]);
		end
		$display("Test modem lines done");
		for (int i = 0; i < 6; i++) begin
			d = lfsr();
			step(umsbg_pkg::umsbg_ctrl_type'({1'b1, d[3:0]}), d[7:4]);
		end
		// Pins go idle while still looped back, so leaving is one change.
		step(umsbg_pkg::umsbg_ctrl_type'({1'b1, d[3:0]}), 4'h0);
		step(5'h00, 4'h0);
		$display("Test loopback done");
		wr(3'h1, 8'hff);
		wr(3'h0, 8'hff);
		foreach (divT[i]) baud(divT[i], divT[i][15]);
		repeat (4) @(posedge clk);
		test_done();
	end

	// Cuts a hung run short.
	initial begin
		#900000;
		failures++;
		test_done();
	end
endmodule
`default_nettype wire
